// [logic/pipelined_sram_access.v]
// pipelined synchronous burst sram, common data i/o, 256k x 18
// assumes the bus master drives all synchronous inputs on i_clk;
// write data passes a 16-word fifo before reaching the array.
// Summary of operation
// - all synchronous inputs registered; read data leaves via output registers
// - controller strobe low captures full address and loads burst counter
// - both strobes low: processor strobe acts, controller strobe disregarded
// - sleep request high puts device to sleep, contents kept; default awake
// - data and parity inputs captured into data register on rising edge
// - data pins driven while output enable low, released while high
// - mode strap low gives linear order, high gives interleaved; static
// - two-bit wrapping burst counter holds start, steps on advance
// - byte lanes written per lane select with byte enable; global writes all
// - writes complete internally from registered controls, no external pulse
// - three synchronous chip selects; with select a high, processor strobe starts nothing but still masks controller strobe
// - read starts when strobe low, selected, global and byte write high
// - read data latched in output register, driven next edge if enabled
// - first read cycle after deselect keeps outputs released
// - back-to-back single reads accepted on successive clocks
// - deselect with a strobe releases data outputs immediately
// - select a and b active low, select high active high
// - advance low steps burst counter, for reads and writes
// - linear adds count modulo four; interleaved xors start with count
`timescale 1ns/1ps
`include "sram_access_consts.vh"

module pipelined_sram_access (
    input  wire                i_clk,
    input  wire                i_rst_n,
    input  wire [`ADDR_W-1:0]  i_address,
    input  wire                i_processor_address_strobe_n,
    input  wire                i_controller_address_strobe_n,
    input  wire                i_burst_advance_n,
    input  wire                i_chip_select_low_a_n,
    input  wire                i_chip_select_high,
    input  wire                i_chip_select_low_b_n,
    input  wire                i_global_write_n,
    input  wire                i_byte_write_enable_n,
    input  wire [1:0]          i_byte_lane_select_n,
    input  wire                i_output_enable_n,
    input  wire                i_mode_strap,
    input  wire                i_sleep_request,
    input  wire [`DATA_W-1:0]  i_data_lines,
    input  wire [`PAR_W-1:0]   i_parity_lines,
    output wire [`DATA_W-1:0]  o_data_lines,
    output wire [`PAR_W-1:0]   o_parity_lines,
    output wire                o_data_oe,
    output wire                o_sleeping,
    output wire                o_write_ready
);

    // ==========================================================
    // input registers
    reg [`ADDR_W-1:0] addr_in_r;
    reg               processor_address_strobe_n_r;
    reg               controller_address_strobe_n_r;
    reg               adv_n_r;
    reg               cs_a_n_r;
    reg               cs_h_r;
    reg               cs_b_n_r;
    reg               gw_n_r;
    reg               bwe_n_r;
    reg [1:0]         bw_n_r;
    reg [`DATA_W-1:0] din_r;
    reg [`PAR_W-1:0]  pin_r;
    reg               mode_r;

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            addr_in_r <= `ADDR_RST;
            processor_address_strobe_n_r  <= 1'b1;
            controller_address_strobe_n_r  <= 1'b1;
            adv_n_r   <= 1'b1;
            cs_a_n_r  <= 1'b1;
            cs_h_r    <= 1'b0;
            cs_b_n_r  <= 1'b1;
            gw_n_r    <= 1'b1;
            bwe_n_r   <= 1'b1;
            bw_n_r    <= 2'h3;
            din_r     <= 16'h0000;
            pin_r     <= 2'h0;
            mode_r    <= 1'b1;
        end
        else
        begin
            addr_in_r <= i_address;
            processor_address_strobe_n_r  <= i_processor_address_strobe_n;
            controller_address_strobe_n_r  <= i_controller_address_strobe_n;
            adv_n_r   <= i_burst_advance_n;
            cs_a_n_r  <= i_chip_select_low_a_n;
            cs_h_r    <= i_chip_select_high;
            cs_b_n_r  <= i_chip_select_low_b_n;
            gw_n_r    <= i_global_write_n;
            bwe_n_r   <= i_byte_write_enable_n;
            bw_n_r    <= i_byte_lane_select_n;
            din_r     <= i_data_lines;
            pin_r     <= i_parity_lines;
            mode_r    <= i_mode_strap;
        end
    end

    // ==========================================================
    // sleep state: two cycles to enter, three to leave
    localparam SL_AWAKE = 3'b001;
    localparam SL_ENTER = 3'b010;
    localparam SL_SLEEP = 3'b100;
    reg [2:0] sleep_r;
    reg [2:0] sleep_nxt;
    reg       zz_s1_r;
    reg       zz_s2_r;
    reg [1:0] wake_cnt_r;

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            zz_s1_r <= 1'b0;
            zz_s2_r <= 1'b0;
        end
        else
        begin
            zz_s1_r <= i_sleep_request;
            zz_s2_r <= zz_s1_r;
        end
    end

    always @*
    begin
        sleep_nxt = sleep_r;
        case (sleep_r)
            SL_AWAKE: if (zz_s2_r) sleep_nxt = SL_ENTER;
            SL_ENTER: sleep_nxt = zz_s2_r ? SL_SLEEP : SL_AWAKE;
            SL_SLEEP: if (!zz_s2_r && wake_cnt_r == 2'd`SLEEP_CYCLES)
                          sleep_nxt = SL_AWAKE;
            default:  sleep_nxt = SL_AWAKE;
        endcase
    end

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sleep_r    <= SL_AWAKE;
            wake_cnt_r <= 2'd0;
        end
        else
        begin
            sleep_r <= sleep_nxt;
            if (sleep_r != SL_SLEEP || zz_s2_r)
                wake_cnt_r <= 2'd0;
            else if (wake_cnt_r != 2'd`SLEEP_CYCLES)
                wake_cnt_r <= wake_cnt_r + 2'd1;
        end
    end

    wire awake = (sleep_r == SL_AWAKE);
    assign o_sleeping = (sleep_r == SL_SLEEP);

    // ==========================================================
    // cycle decode
    reg        active_r;
    reg        pend_r;
    wire selected   = ~cs_a_n_r & cs_h_r & ~cs_b_n_r;
    wire processor_address_strobe_ok    = ~processor_address_strobe_n_r & ~cs_a_n_r;
    wire controller_address_strobe_ok    = ~controller_address_strobe_n_r & processor_address_strobe_n_r;
    wire strobe     = awake & (processor_address_strobe_ok | controller_address_strobe_ok);
    wire start      = strobe & selected;
    wire deselect   = strobe & ~selected;
    wire wr_req     = ~gw_n_r | ~bwe_n_r;
    wire rd_start   = start & (processor_address_strobe_ok | ~wr_req);
    wire controller_address_strobe_wr    = start & controller_address_strobe_ok & wr_req;
    wire cont       = awake & ~strobe & active_r;
    wire [1:0] lanes = ~gw_n_r ? 2'b11 :
                       (~bwe_n_r ? ~bw_n_r : 2'b00);

    // ==========================================================
    // address register and burst counter
    reg [`ADDR_W-1:0] addr_r;
    reg [1:0]         bstart_r;
    reg [1:0]         bcount_r;
    // advancing cycle already uses the next count
    wire [1:0] bnext = bcount_r + {1'b0, cont & ~adv_n_r};
    wire [1:0] blow = mode_r ? (bstart_r ^ bnext) :
                               (bstart_r + bnext);
    wire [`ADDR_W-1:0] cur_addr = {addr_r[`ADDR_W-1:2], blow};

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            active_r <= 1'b0;
            pend_r   <= 1'b0;
            addr_r   <= `ADDR_RST;
            bstart_r <= `BURST_RST;
            bcount_r <= `BURST_RST;
        end
        else
        begin
            pend_r <= start & processor_address_strobe_ok;
            if (start)
            begin
                active_r <= 1'b1;
                addr_r   <= addr_in_r;
                bstart_r <= addr_in_r[1:0];
                bcount_r <= `BURST_RST;
            end
            else
            begin
                if (deselect || !awake)
                    active_r <= 1'b0;
                if (cont && !adv_n_r)
                    bcount_r <= bcount_r + 2'd1;
                // otherwise the counter holds
            end
        end
    end

    // ==========================================================
    // write path through fifo into the array
    wire cont_wr   = cont & wr_req & ~pend_r;
    wire pend_wr   = pend_r & awake & ~strobe & wr_req;
    wire wr_fire   = (controller_address_strobe_wr | pend_wr | cont_wr) & (|lanes);
    wire [`ADDR_W-1:0] wr_addr = controller_address_strobe_wr ? addr_in_r : cur_addr;
    wire [`WORD_W-1:0] wr_word = {pin_r[1], din_r[15:8], pin_r[0], din_r[7:0]};
    wire [37:0] f_in = {lanes, wr_addr, wr_word};
    wire [37:0] f_out;
    wire        f_valid;
    wire        f_ready;
    wire        f_pop  = f_valid & awake & ~rd_start;

    assign o_write_ready = f_ready;

    word_fifo #(
        .WIDTH (38),
        .DEPTH (`FIFO_DEPTH),
        .PTR_W (`FIFO_PTR_W)
    ) u_wfifo (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_data  (f_in),
        .i_valid (wr_fire),
        .o_ready (f_ready),
        .o_data  (f_out),
        .o_valid (f_valid),
        .i_ready (f_pop)
    );

    reg [`LANE_W-1:0] mem_lo [0:`MEM_DEPTH-1];
    reg [`LANE_W-1:0] mem_hi [0:`MEM_DEPTH-1];
    wire [`ADDR_W-1:0] m_addr = f_out[35:18];

    always @(posedge i_clk)
    begin
        if (f_pop && f_out[36])
            mem_lo[m_addr] <= f_out[8:0];
        if (f_pop && f_out[37])
            mem_hi[m_addr] <= f_out[17:9];
    end

    // ==========================================================
    // read pipeline and output register
    // continuation reads wait for queued writes to land
    wire rd_any = rd_start | (cont & ~wr_req & ~pend_r & ~f_valid);
    wire [`ADDR_W-1:0] rd_addr = rd_start ? addr_in_r : cur_addr;
    reg  [`WORD_W-1:0] dout_r;
    reg                drive_r;
    reg                was_desel_r;

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            dout_r      <= `WORD_RST;
            drive_r     <= 1'b0;
            was_desel_r <= 1'b1;
        end
        else
        begin
            if (rd_any)
                dout_r <= {mem_hi[rd_addr], mem_lo[rd_addr]};
            // first read out of deselect stays released
            drive_r <= rd_any & ~(rd_start & was_desel_r);
            if (deselect || !awake)
                was_desel_r <= 1'b1;
            else if (start)
                was_desel_r <= 1'b0;
        end
    end

    assign o_data_lines   = {dout_r[16:9], dout_r[7:0]};
    assign o_parity_lines = {dout_r[17], dout_r[8]};
    // release on deselect or write, else follow output enable
    assign o_data_oe = drive_r & ~i_output_enable_n & ~deselect
                       & ~(wr_req & active_r);

endmodule

// [logic/sram_access_consts.vh]
// constants for the pipelined sram access block
// assumes one rising-edge clock and an active-low asynchronous reset
`ifndef SRAM_ACCESS_CONSTS_VH
`define SRAM_ACCESS_CONSTS_VH

`define ADDR_W          18
`define DATA_W          16
`define PAR_W           2
`define LANE_W          9
`define WORD_W          18
`define BURST_W         2
`define MEM_DEPTH       262144
`define FIFO_DEPTH      16
`define FIFO_PTR_W      4
`define SLEEP_CYCLES    2
`define BURST_RST       2'h0
`define ADDR_RST        18'h0_0000
`define WORD_RST        18'h0_0000

`endif

// [logic/word_fifo.v]
// word fifo with valid/ready on both sides
// assumes a single clock; full and empty are exact
`timescale 1ns/1ps

module word_fifo #(
    parameter WIDTH = 18,
    parameter DEPTH = 16,
    parameter PTR_W = 4
)(
    input  wire             i_clk,
    input  wire             i_rst_n,
    input  wire [WIDTH-1:0] i_data,
    input  wire             i_valid,
    output wire             o_ready,
    output wire [WIDTH-1:0] o_data,
    output wire             o_valid,
    input  wire             i_ready
);

    // ==========================================================
    // storage and pointers
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [PTR_W-1:0] wr_ptr_r;
    reg [PTR_W-1:0] rd_ptr_r;
    reg [PTR_W:0]   count_r;
    wire            push;
    wire            pop;

    assign o_ready = (count_r != DEPTH[PTR_W:0]);
    assign o_valid = (count_r != {(PTR_W+1){1'b0}});
    assign o_data  = mem[rd_ptr_r];
    assign push    = i_valid & o_ready;
    assign pop     = o_valid & i_ready;

    always @(posedge i_clk)
    begin
        if (push)
            mem[wr_ptr_r] <= i_data;
    end

    always @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr_r <= {PTR_W{1'b0}};
            rd_ptr_r <= {PTR_W{1'b0}};
            count_r  <= {(PTR_W+1){1'b0}};
        end
        else
        begin
            if (push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            if (push & ~pop)
                count_r <= count_r + 1'b1;
            else if (pop & ~push)
                count_r <= count_r - 1'b1;
        end
    end

endmodule

// [verification/bus_master_model.sv]
// far-side bus master model resolving the shared data lines
// assumes one clock; released lines show the inverse of the last level
`timescale 1ns/1ps
module bus_master_model (
    input  wire logic        i_clk,
    input  wire logic        i_drive,
    input  wire logic [17:0] i_word,
    input  wire logic        i_dev_oe,
    input  wire logic [15:0] i_dev_data,
    input  wire logic [1:0]  i_dev_par,
    output logic      [15:0] o_data,
    output logic      [1:0]  o_par
);
    logic [17:0] bus;
    logic [17:0] last_r = 18'h0_0000;
    always @(posedge i_clk) last_r <= bus;
    always_comb
        if (i_dev_oe)
            bus = {i_dev_par[1], i_dev_data[15:8], i_dev_par[0], i_dev_data[7:0]};
        else if (i_drive)
            bus = i_word;
        else
            bus = ~last_r;
    assign o_data = {bus[16:9], bus[7:0]};
    assign o_par = {bus[17], bus[8]};
endmodule

// [verification/sram_access_sva.sv]
// assertions on the pipelined sram access top ports
// assumes bind onto pipelined_sram_access, one clock domain
`timescale 1ns/1ps
module sram_access_sva (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_processor_address_strobe_n,
    input wire logic        i_controller_address_strobe_n,
    input wire logic        i_chip_select_low_a_n,
    input wire logic        i_chip_select_high,
    input wire logic        i_chip_select_low_b_n,
    input wire logic        i_global_write_n,
    input wire logic        i_byte_write_enable_n,
    input wire logic        i_output_enable_n,
    input wire logic        i_sleep_request,
    input wire logic [15:0] o_data_lines,
    input wire logic        o_data_oe,
    input wire logic        o_sleeping
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // ========
    // decoded request terms
    wire sel = !i_chip_select_low_a_n && i_chip_select_high && !i_chip_select_low_b_n;
    wire stb = (!i_processor_address_strobe_n && !i_chip_select_low_a_n)
               || !i_controller_address_strobe_n;
    wire nowr = i_global_write_n && i_byte_write_enable_n;
    wire awake = !i_sleep_request && !o_sleeping;
    wire quiet = i_processor_address_strobe_n && i_controller_address_strobe_n && nowr && awake;
    sequence read_go;
        stb && sel && nowr && awake;
    endsequence
    sequence hold_on;
        (quiet && !i_output_enable_n)[*4];
    endsequence
    // ========
    // checks
    AST_OE_GATED: assert property (o_data_oe |-> !i_output_enable_n)
        else $error("data driven while output enable high");
    AST_READ_DRIVES: assert property (read_go ##1 hold_on |-> o_data_oe)
        else $error("read data not driven");
    AST_DESELECT_OFF: assert property (stb && !sel && awake |-> ##2 !o_data_oe)
        else $error("outputs kept after deselect");
    AST_WRITE_OFF: assert property (stb && sel && !i_global_write_n
        && i_processor_address_strobe_n && awake |-> ##2 !o_data_oe)
        else $error("outputs driven during write");
    AST_PROC_IGNORED: assert property (quiet[*3] ##1 (!i_processor_address_strobe_n
        && i_chip_select_low_a_n && i_controller_address_strobe_n && awake && !o_data_oe)
        |=> (!o_data_oe)[*2])
        else $error("processor strobe acted with select a high");
    AST_SLEEP_IN: assert property (i_sleep_request[*8] |-> o_sleeping)
        else $error("sleep not entered");
    AST_SLEEP_OUT: assert property ((!i_sleep_request)[*8] |-> !o_sleeping)
        else $error("sleep not left");
    AST_DATA_STANDS: assert property (quiet[*4] ##0 o_data_oe ##1 o_data_oe
        |-> $stable(o_data_lines))
        else $error("output data changed without a read");
endmodule
bind pipelined_sram_access sram_access_sva sram_access_sva_i (.i_clk, .i_rst_n,
    .i_processor_address_strobe_n, .i_controller_address_strobe_n,
    .i_chip_select_low_a_n, .i_chip_select_high, .i_chip_select_low_b_n,
    .i_global_write_n, .i_byte_write_enable_n, .i_output_enable_n,
    .i_sleep_request, .o_data_lines, .o_data_oe, .o_sleeping);

// [verification/tb_top.sv]
// self-checking bench for pipelined_sram_access
// assumes bus_master_model resolves the shared data lines
`timescale 1ns/1ps
module tb_top;
    logic        i_clk = 0, i_rst_n = 0, p_n = 1, c_n = 1, v_n = 1, sa_n = 1, sh = 1;
    logic        sb_n = 0, g_n = 1, e_n = 1, oe_n = 0, mode = 0, zz = 0, drv = 0;
    logic [17:0] a = 18'h0_0000, w = 18'h0_0000;
    logic [1:0]  l_n = 2'h3;
    wire  [15:0] d_in, d_out;
    wire  [1:0]  p_in, p_out;
    wire         oe, slp, wr_rdy;
    int          mismatches = 0, samples_checked = 0, cnt = 0, seed = 10246;
    logic [17:0] mem [int];
    typedef struct {int due; logic [17:0] v;} note_t;
    note_t       q [$];
    always #20 i_clk = ~i_clk;
    always @(posedge i_clk) cnt <= cnt + 1;
    pipelined_sram_access pipelined_sram_access_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_address(a), .i_processor_address_strobe_n(p_n),
        .i_controller_address_strobe_n(c_n), .i_burst_advance_n(v_n),
        .i_chip_select_low_a_n(sa_n), .i_chip_select_high(sh), .i_chip_select_low_b_n(sb_n),
        .i_global_write_n(g_n), .i_byte_write_enable_n(e_n), .i_byte_lane_select_n(l_n),
        .i_output_enable_n(oe_n), .i_mode_strap(mode), .i_sleep_request(zz),
        .i_data_lines(d_in), .i_parity_lines(p_in), .o_data_lines(d_out),
        .o_parity_lines(p_out), .o_data_oe(oe), .o_sleeping(slp), .o_write_ready(wr_rdy));
    bus_master_model bus_master_model_i (.i_clk(i_clk), .i_drive(drv), .i_word(w),
        .i_dev_oe(oe), .i_dev_data(d_out), .i_dev_par(p_out), .o_data(d_in), .o_par(p_in));
    // ========
    // compare, report, end
    task automatic check(input string n, input logic [17:0] s, input logic [17:0] e);
        samples_checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(negedge i_clk)
        if (q.size() > 0 && q[0].due == cnt)
        begin
            check("read word", {p_out[1], d_out[15:8], p_out[0], d_out[7:0]}, q[0].v);
            void'(q.pop_front());
        end
    // ========
    // one bus cycle: 0 idle 1 read 2 write 3 byte write 4 advance
    // 5 both strobes 6 deselect 7 processor strobe with select a high
    task automatic bus(input int k, input logic [17:0] ad, input logic [1:0] ln);
        logic [17:0] r;
        r = $random(seed);
        @(posedge i_clk);
        p_n <= !(k == 5 || k == 7);
        c_n <= !(k inside {1, 2, 3, 5, 6});
        v_n <= k != 4;
        sa_n <= k == 7;
        sh <= k != 6;
        g_n <= !(k == 2 || k == 5);
        e_n <= k != 3;
        l_n <= ln;
        oe_n <= k == 2 || k == 3;
        drv <= k == 2 || k == 3;
        a <= ad;
        w <= r;
        if (k == 2) mem[ad] = r;
        if (k == 3 && !ln[1]) mem[ad][17:9] = r[17:9];
        if (k == 3 && !ln[0]) mem[ad][8:0] = r[8:0];
        if (k inside {1, 4, 5}) q.push_back('{cnt + 3, mem[ad]});
    endtask
    task automatic wait_sleep(input logic x);
        int n;
        n = 0;
        while (slp !== x && n < 50)
        begin
            @(posedge i_clk);
            n++;
        end
        check("sleep state", {17'h0_0000, slp}, {17'h0_0000, x});
        if (slp !== x) stop_test();
    endtask
    initial
    begin
        repeat (20000) @(posedge i_clk);
        mismatches++;
        stop_test();
    end
    initial
    begin
        logic [17:0] b;
        for (int m = 0; m < 2; m++)
        begin
            i_rst_n <= 1'h0;
            mode <= m[0];
            repeat (20) @(posedge i_clk);
            check("reset outputs", {15'h0000, oe, slp, wr_rdy}, 18'h0_0001);
            i_rst_n <= 1'h1;
            b = $random(seed) & 18'h3_fff8;
            for (int i = 0; i < 8; i++)
                bus(2, b + i, $random(seed));
            bus(3, b + 1, 2'h2);
            bus(3, b + 2, 2'h3);
            repeat (24) bus(0, b, 2'h3);
            for (int i = 0; i < 16; i++)
                bus(i % 2 ? 5 : 1, b + ($random(seed) & 7), 2'h3);
            for (int s = 0; s < 4; s++)
                for (int k = 0; k < 4; k++)
                    bus(k ? 4 : 1, {b[17:2], m ? 2'(s ^ k) : 2'(s + k)}, 2'h3);
            bus(6, b, 2'h3);
            repeat (4) bus(0, b, 2'h3);
            bus(7, b, 2'h3);
            repeat (6) bus(0, b, 2'h3);
            zz <= 1'h1;
            wait_sleep(1'h1);
            zz <= 1'h0;
            wait_sleep(1'h0);
            $display("mode %0d pass done", m);
        end
        stop_test();
    end
endmodule
